// ==== core/dout_select_defs.svh ====
// offsets, field layout, reset values and timing counts for the digital output selector
// included by the selector design module and the testbench top
`ifndef DOUT_SELECT_DEFS_SVH
`define DOUT_SELECT_DEFS_SVH

// register offsets (word index on the plain register port)
`define OFS_TYPE_SEL 4'h0
`define OFS_OC_SEL 4'h1
`define OFS_FAST_SEL 4'h2
`define OFS_RELAY_A_SEL 4'h3
`define OFS_RELAY_B_SEL 4'h4
`define OFS_POLARITY 4'h5
`define OFS_CARD_ENABLE 4'h6
`define OFS_VIRTUAL_BITS 4'h7
`define OFS_TERM_STATE 4'h8

// reset values
`define RST_TYPE_SEL 1'h0
`define RST_OC_SEL 6'h00
`define RST_FAST_SEL 6'h00
`define RST_RELAY_A_SEL 6'h01
`define RST_RELAY_B_SEL 6'h05
`define RST_POLARITY 4'h0

// virtual-bit register field positions, 4 bits per link
`define VB_MODBUS_LSB 0
`define VB_FIELDBUS_LSB 4
`define VB_ETH_LSB 8
`define VB_RTETH_LSB 12

// index pulse width
`define INDEX_PULSE_NS 10000000
`define CLK_PERIOD_NS 40

`endif

// ==== core/dout_select_pkg.sv ====
// types shared by the digital output selector
// assumes dout_select_defs.svh holds the numeric constants
package dout_select_pkg;

  // terminal order inside every 4-bit vector
  typedef enum logic [1:0] {
    TERM_OC = 2'h0,
    TERM_FAST = 2'h1,
    TERM_RELAY_A = 2'h2,
    TERM_RELAY_B = 2'h3
  } term_e;

  // select code field
  typedef logic [5:0] sel_code_t;

  // index pulse stretcher states
  typedef enum logic [1:0] {
    ZP_IDLE = 2'h1,
    ZP_HOLD = 2'h2
  } zpulse_e;

endpackage

// ==== core/dout_select.sv ====
// four-terminal digital output function selector with plain register port
// assumes status inputs are synchronous to clk_sys and come from drive control logic
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "dout_select_defs.svh"

// Operation
// - each of four terminals has its own select; fast terminal also pulse or on/off
// - same code on several terminals drives all from the same condition, except codes 23,24,25,34 (one bit per terminal)
// - code 0 leaves the terminal inactive
// - codes 1-4 follow running, forward, reverse and jogging frequency output
// - code 5 turns on while a drive fault is present
// - code 9 on only when output and reference frequency both zero
// - codes 10 and 11 follow upper and lower limit frequency reached
// - code 12 on when powers are up, no protection, ready to run
// - code 13 on for the whole pre-excitation
// - codes 14 and 15 follow timed overload and underload pre-alarms
// - codes 16 and 17 signal sequence stage and cycle completion
// - codes 23,24,25,34 follow the bit written over each link
// - code 26 on while bus voltage is above undervoltage threshold
// - code 27 gives a 10 ms pulse from the encoder index pulse
// - code 28 on while pulse superposition is active
// - code 29 on when a safe-torque-off fault occurred
// - codes 30-32 follow positioning, spindle zeroing and scale-division done
// - code 33 on while frequency is held by a speed limit
// - code 36 on once the speed/position switch-over completed
// - codes 41-47 pass card outputs, only when card output enable is 1
// - 4-bit polarity mask inverts each terminal before output, except the fast terminal in pulse mode
// - fast terminal type 0 is pulse, 1 is on/off using its select
module dout_select #(
  parameter int unsigned INDEX_PULSE_CYCLES = `INDEX_PULSE_NS / `CLK_PERIOD_NS
) (
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_ff,
  // drive status conditions
  input wire logic st_running,
  input wire logic st_forward,
  input wire logic st_reverse,
  input wire logic st_jogging,
  input wire logic st_fault,
  input wire logic st_zero_speed,
  input wire logic st_upper_limit,
  input wire logic st_lower_limit,
  input wire logic st_ready,
  input wire logic st_preexcite,
  input wire logic st_overload_alarm,
  input wire logic st_underload_alarm,
  input wire logic st_stage_done,
  input wire logic st_cycle_done,
  input wire logic st_bus_ok,
  input wire logic st_index_pulse,
  input wire logic st_pulse_superpose,
  input wire logic st_safe_torque_off,
  input wire logic st_position_done,
  input wire logic st_spindle_zero_done,
  input wire logic st_spindle_div_done,
  input wire logic st_speed_limit,
  input wire logic st_mode_switch_done,
  // programmable card outputs, bit 0 = card_oc_bit_1 .. bit 6 = card_relay_bit_4
  input wire logic [6:0] card_bits,
  // pulse train from the pulse generator, used when the fast terminal is in pulse mode
  input wire logic fast_pulse_in,
  // terminals
  output logic oc_terminal_ff,
  output logic fast_pulse_terminal_ff,
  output logic relay_terminal_a_ff,
  output logic relay_terminal_b_ff
);

  localparam int unsigned NTERM = 4;
  localparam int unsigned ZP_W = $clog2(INDEX_PULSE_CYCLES + 1);

  // configuration registers
  logic fast_terminal_type_ff;
  dout_select_pkg::sel_code_t sel_ff [NTERM];
  logic [3:0] output_polarity_mask_ff;
  logic card_output_enable_ff;
  logic [15:0] virtual_bits_ff;

  // index pulse stretcher
  dout_select_pkg::zpulse_e zp_state_ff;
  logic [ZP_W-1:0] zp_count_ff;
  logic index_stretch;

  // per-terminal selected level
  logic [NTERM-1:0] selected;
  logic [NTERM-1:0] driven;

  // register writes; select codes are 6 bits wide
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fast_terminal_type_ff <= `RST_TYPE_SEL;
      sel_ff[dout_select_pkg::TERM_OC] <= `RST_OC_SEL;
      sel_ff[dout_select_pkg::TERM_FAST] <= `RST_FAST_SEL;
      sel_ff[dout_select_pkg::TERM_RELAY_A] <= `RST_RELAY_A_SEL;
      sel_ff[dout_select_pkg::TERM_RELAY_B] <= `RST_RELAY_B_SEL;
      output_polarity_mask_ff <= `RST_POLARITY;
      card_output_enable_ff <= 1'h0;
      virtual_bits_ff <= 16'h0000;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `OFS_TYPE_SEL: fast_terminal_type_ff <= reg_wdata[0];
        `OFS_OC_SEL: sel_ff[dout_select_pkg::TERM_OC] <= reg_wdata[5:0];
        `OFS_FAST_SEL: sel_ff[dout_select_pkg::TERM_FAST] <= reg_wdata[5:0];
        `OFS_RELAY_A_SEL: sel_ff[dout_select_pkg::TERM_RELAY_A] <= reg_wdata[5:0];
        `OFS_RELAY_B_SEL: sel_ff[dout_select_pkg::TERM_RELAY_B] <= reg_wdata[5:0];
        `OFS_POLARITY: output_polarity_mask_ff <= reg_wdata[3:0];
        `OFS_CARD_ENABLE: card_output_enable_ff <= reg_wdata[0];
        `OFS_VIRTUAL_BITS: virtual_bits_ff <= reg_wdata;
        default: ; // unmapped or read-only: write ignored
      endcase
    end
  end

  // read data, valid in the cycle after the strobe only; unmapped reads give zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `OFS_TYPE_SEL: reg_rdata_ff <= {15'h0000, fast_terminal_type_ff};
        `OFS_OC_SEL: reg_rdata_ff <= {10'h000, sel_ff[dout_select_pkg::TERM_OC]};
        `OFS_FAST_SEL: reg_rdata_ff <= {10'h000, sel_ff[dout_select_pkg::TERM_FAST]};
        `OFS_RELAY_A_SEL: reg_rdata_ff <= {10'h000, sel_ff[dout_select_pkg::TERM_RELAY_A]};
        `OFS_RELAY_B_SEL: reg_rdata_ff <= {10'h000, sel_ff[dout_select_pkg::TERM_RELAY_B]};
        `OFS_POLARITY: reg_rdata_ff <= {12'h000, output_polarity_mask_ff};
        `OFS_CARD_ENABLE: reg_rdata_ff <= {15'h0000, card_output_enable_ff};
        `OFS_VIRTUAL_BITS: reg_rdata_ff <= virtual_bits_ff;
        `OFS_TERM_STATE: reg_rdata_ff <= {12'h000, relay_terminal_b_ff, relay_terminal_a_ff,
                                          fast_pulse_terminal_ff, oc_terminal_ff};
        default: reg_rdata_ff <= 16'h0000;
      endcase
    end else begin
      reg_rdata_ff <= 16'h0000;
    end
  end

  // index pulse stretched to a fixed width; a new pulse while holding restarts the width
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      zp_state_ff <= dout_select_pkg::ZP_IDLE;
      zp_count_ff <= '0;
    end else begin
      unique case (zp_state_ff)
        dout_select_pkg::ZP_IDLE: begin
          if (st_index_pulse) begin
            zp_state_ff <= dout_select_pkg::ZP_HOLD;
            zp_count_ff <= ZP_W'(INDEX_PULSE_CYCLES - 1);
          end
        end
        dout_select_pkg::ZP_HOLD: begin
          if (st_index_pulse) begin
            zp_count_ff <= ZP_W'(INDEX_PULSE_CYCLES - 1);
          end else if (zp_count_ff == '0) begin
            zp_state_ff <= dout_select_pkg::ZP_IDLE;
          end else begin
            zp_count_ff <= zp_count_ff - 1'b1;
          end
        end
        default: zp_state_ff <= dout_select_pkg::ZP_IDLE;
      endcase
    end
  end

  assign index_stretch = (zp_state_ff == dout_select_pkg::ZP_HOLD);

  // one selector per terminal; sharing a code reads the same condition, except link codes, which read each terminal's own bit
  genvar gi;
  generate
    for (gi = 0; gi < NTERM; gi++) begin : g_term
      always_comb begin
        unique case (sel_ff[gi])
          6'h00: selected[gi] = 1'b0;
          6'h01: selected[gi] = st_running;
          6'h02: selected[gi] = st_forward;
          6'h03: selected[gi] = st_reverse;
          6'h04: selected[gi] = st_jogging;
          6'h05: selected[gi] = st_fault;
          6'h09: selected[gi] = st_zero_speed;
          6'h0A: selected[gi] = st_upper_limit;
          6'h0B: selected[gi] = st_lower_limit;
          6'h0C: selected[gi] = st_ready;
          6'h0D: selected[gi] = st_preexcite;
          6'h0E: selected[gi] = st_overload_alarm; // timing done upstream
          6'h0F: selected[gi] = st_underload_alarm;
          6'h10: selected[gi] = st_stage_done;
          6'h11: selected[gi] = st_cycle_done;
          6'h17: selected[gi] = virtual_bits_ff[`VB_MODBUS_LSB + gi];
          6'h18: selected[gi] = virtual_bits_ff[`VB_FIELDBUS_LSB + gi];
          6'h19: selected[gi] = virtual_bits_ff[`VB_ETH_LSB + gi];
          6'h22: selected[gi] = virtual_bits_ff[`VB_RTETH_LSB + gi];
          6'h1A: selected[gi] = st_bus_ok;
          6'h1B: selected[gi] = index_stretch;
          6'h1C: selected[gi] = st_pulse_superpose;
          6'h1D: selected[gi] = st_safe_torque_off;
          6'h1E: selected[gi] = st_position_done;
          6'h1F: selected[gi] = st_spindle_zero_done;
          6'h20: selected[gi] = st_spindle_div_done;
          6'h21: selected[gi] = st_speed_limit;
          6'h24: selected[gi] = st_mode_switch_done;
          // card bits pass only while the card output is enabled
          6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h2F:
            selected[gi] = card_output_enable_ff & card_bits[3'(sel_ff[gi] - 6'h29)];
          default: selected[gi] = 1'b0; // reserved codes act as code 0
        endcase
      end
      // polarity applied last so an idle terminal can be made normally-on
      assign driven[gi] = selected[gi] ^ output_polarity_mask_ff[gi];
    end
  endgenerate

  // registered terminals; fast terminal in pulse mode bypasses the selector
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      oc_terminal_ff <= 1'b0;
      fast_pulse_terminal_ff <= 1'b0;
      relay_terminal_a_ff <= 1'b0;
      relay_terminal_b_ff <= 1'b0;
    end else begin
      oc_terminal_ff <= driven[dout_select_pkg::TERM_OC];
      fast_pulse_terminal_ff <= fast_terminal_type_ff ? driven[dout_select_pkg::TERM_FAST]
                                                      : fast_pulse_in;
      relay_terminal_a_ff <= driven[dout_select_pkg::TERM_RELAY_A];
      relay_terminal_b_ff <= driven[dout_select_pkg::TERM_RELAY_B];
    end
  end

  // assertions
  property p_code_zero_idle;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_OC] == 6'h00) |=> (oc_terminal_ff == $past(output_polarity_mask_ff[0]));
  endproperty
  a_code_zero_idle: assert property (p_code_zero_idle) else $error("code 0 terminal not idle");

  property p_running;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_RELAY_A] == 6'h01 && !output_polarity_mask_ff[2])
        |=> (relay_terminal_a_ff == $past(st_running));
  endproperty
  a_running: assert property (p_running) else $error("relay a does not follow running");

  property p_fault;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_RELAY_B] == 6'h05 && !output_polarity_mask_ff[3] && st_fault)
        |=> relay_terminal_b_ff;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not shown on relay b");

  property p_reserved;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_OC] inside {6'h12, 6'h23, 6'h28, 6'h30, 6'h3F} && !output_polarity_mask_ff[0])
        |=> !oc_terminal_ff;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code drove terminal");

  property p_card_gate;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_OC] == 6'h29 && !card_output_enable_ff && !output_polarity_mask_ff[0])
        |=> !oc_terminal_ff;
  endproperty
  a_card_gate: assert property (p_card_gate) else $error("card bit passed while disabled");

  property p_index_width;
    @(posedge clk_sys) disable iff (reset)
      (zp_state_ff == dout_select_pkg::ZP_IDLE && st_index_pulse) ##1 (!st_index_pulse)[*3]
        |-> index_stretch;
  endproperty
  a_index_width: assert property (p_index_width) else $error("index pulse stretch too short");

  property p_pulse_mode;
    @(posedge clk_sys) disable iff (reset)
      !fast_terminal_type_ff |=> (fast_pulse_terminal_ff == $past(fast_pulse_in));
  endproperty
  a_pulse_mode: assert property (p_pulse_mode) else $error("fast terminal not in pulse mode");

  property p_polarity;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_RELAY_A] == 6'h00 && output_polarity_mask_ff[2]) ##1
        (sel_ff[dout_select_pkg::TERM_RELAY_A] == 6'h00) |-> relay_terminal_a_ff;
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity inversion missing");

  // virtual-link codes carry one bit per terminal, so only shared conditions must agree
  property p_same_code;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_RELAY_A] == sel_ff[dout_select_pkg::TERM_RELAY_B] &&
       output_polarity_mask_ff[2] == output_polarity_mask_ff[3] &&
       !(sel_ff[dout_select_pkg::TERM_RELAY_A] inside {6'h17, 6'h18, 6'h19, 6'h22}))
        |=> (relay_terminal_a_ff == relay_terminal_b_ff);
  endproperty
  a_same_code: assert property (p_same_code) else $error("shared code drove relays apart");

  property p_zero_speed;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_OC] == 6'h09 && !output_polarity_mask_ff[0])
        |=> (oc_terminal_ff == $past(st_zero_speed));
  endproperty
  a_zero_speed: assert property (p_zero_speed) else $error("zero speed not on terminal");

  property p_upper_limit;
    @(posedge clk_sys) disable iff (reset)
      (fast_terminal_type_ff && sel_ff[dout_select_pkg::TERM_FAST] == 6'h0A && !output_polarity_mask_ff[1])
        |=> (fast_pulse_terminal_ff == $past(st_upper_limit));
  endproperty
  a_upper_limit: assert property (p_upper_limit) else $error("upper limit not on fast terminal");

  property p_ready;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_RELAY_B] == 6'h0C && !output_polarity_mask_ff[3])
        |=> (relay_terminal_b_ff == $past(st_ready));
  endproperty
  a_ready: assert property (p_ready) else $error("ready not on relay b");

  property p_preexcite;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_RELAY_A] == 6'h0D && !output_polarity_mask_ff[2])
        |=> (relay_terminal_a_ff == $past(st_preexcite));
  endproperty
  a_preexcite: assert property (p_preexcite) else $error("pre-excitation not on relay a");

  property p_overload;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_OC] == 6'h0E && !output_polarity_mask_ff[0])
        |=> (oc_terminal_ff == $past(st_overload_alarm));
  endproperty
  a_overload: assert property (p_overload) else $error("overload alarm not on terminal");

  property p_stage_done;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_RELAY_B] == 6'h10 && !output_polarity_mask_ff[3])
        |=> (relay_terminal_b_ff == $past(st_stage_done));
  endproperty
  a_stage_done: assert property (p_stage_done) else $error("stage done not on relay b");

  property p_fieldbus_bit;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_RELAY_B] == 6'h18 && !output_polarity_mask_ff[3])
        |=> (relay_terminal_b_ff == $past(virtual_bits_ff[`VB_FIELDBUS_LSB + 3]));
  endproperty
  a_fieldbus_bit: assert property (p_fieldbus_bit) else $error("link bit not on relay b");

  property p_bus_ok;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_OC] == 6'h1A && !output_polarity_mask_ff[0])
        |=> (oc_terminal_ff == $past(st_bus_ok));
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus voltage state not on terminal");

  property p_superpose;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_RELAY_A] == 6'h1C && !output_polarity_mask_ff[2])
        |=> (relay_terminal_a_ff == $past(st_pulse_superpose));
  endproperty
  a_superpose: assert property (p_superpose) else $error("superposition not on relay a");

  property p_safe_torque;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_RELAY_B] == 6'h1D && !output_polarity_mask_ff[3])
        |=> (relay_terminal_b_ff == $past(st_safe_torque_off));
  endproperty
  a_safe_torque: assert property (p_safe_torque) else $error("torque-off fault not on relay b");

  property p_position_done;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_OC] == 6'h1E && !output_polarity_mask_ff[0])
        |=> (oc_terminal_ff == $past(st_position_done));
  endproperty
  a_position_done: assert property (p_position_done) else $error("positioning done not shown");

  property p_mode_switch;
    @(posedge clk_sys) disable iff (reset)
      (sel_ff[dout_select_pkg::TERM_RELAY_A] == 6'h24 && !output_polarity_mask_ff[2])
        |=> (relay_terminal_a_ff == $past(st_mode_switch_done));
  endproperty
  a_mode_switch: assert property (p_mode_switch) else $error("mode switch-over not shown");

endmodule
`default_nettype wire

// ==== testbench/dout_load_model.sv ====
// far-side loads of the four output terminals: two relay coils, an indicator and a controller input
// assumes terminals are registered on clk_sys, active high, and are plain levels to the loads
`timescale 1ns/100ps
`default_nettype none
module dout_load_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic oc_terminal_ff,
  input wire logic fast_pulse_terminal_ff,
  input wire logic relay_terminal_a_ff,
  input wire logic relay_terminal_b_ff,
  output logic [3:0] seen_ff
);
  // loads only latch levels; they cannot react inside one clock anyway, so one edge of lag is honest
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      seen_ff <= 4'h0;
    end else begin
      seen_ff <= {relay_terminal_b_ff, relay_terminal_a_ff, fast_pulse_terminal_ff, oc_terminal_ff};
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the digital output selector, integer model compared at every terminal check
// assumes the selector, its package and defines header are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "dout_select_defs.svh"
module tb_top;
  localparam int unsigned PULSE_CYC = 5;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata_ff;
  logic [22:0] st = '0;
  logic [6:0] card_bits = 7'h00;
  logic fast_pulse_in = 1'b0;
  logic oc_terminal_ff, fast_pulse_terminal_ff, relay_terminal_a_ff, relay_terminal_b_ff;
  logic [3:0] seen_ff;
  logic [15:0] rd;
  int err_total = 0;
  int cmp_count = 0;
  int sel_m [4] = '{0, 0, 1, 5};
  int pol_m = 0, type_m = 0, cen_m = 0, vb_m = 0;

  dout_select #(.INDEX_PULSE_CYCLES(PULSE_CYC)) i_dout_select (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .st_running(st[0]), .st_forward(st[1]), .st_reverse(st[2]), .st_jogging(st[3]), .st_fault(st[4]),
    .st_zero_speed(st[5]), .st_upper_limit(st[6]), .st_lower_limit(st[7]), .st_ready(st[8]),
    .st_preexcite(st[9]), .st_overload_alarm(st[10]), .st_underload_alarm(st[11]),
    .st_stage_done(st[12]), .st_cycle_done(st[13]), .st_bus_ok(st[14]), .st_index_pulse(st[15]),
    .st_pulse_superpose(st[16]), .st_safe_torque_off(st[17]), .st_position_done(st[18]),
    .st_spindle_zero_done(st[19]), .st_spindle_div_done(st[20]), .st_speed_limit(st[21]),
    .st_mode_switch_done(st[22]), .card_bits(card_bits), .fast_pulse_in(fast_pulse_in),
    .oc_terminal_ff(oc_terminal_ff), .fast_pulse_terminal_ff(fast_pulse_terminal_ff),
    .relay_terminal_a_ff(relay_terminal_a_ff), .relay_terminal_b_ff(relay_terminal_b_ff)
  );

  dout_load_model i_dout_load_model (
    .clk_sys(clk_sys), .reset(reset), .oc_terminal_ff(oc_terminal_ff),
    .fast_pulse_terminal_ff(fast_pulse_terminal_ff), .relay_terminal_a_ff(relay_terminal_a_ff),
    .relay_terminal_b_ff(relay_terminal_b_ff), .seen_ff(seen_ff)
  );

  // 25 MHz system clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_ff;
  endtask

  // behavioural terminal model: code to condition, then polarity, fast terminal bypass in pulse mode
  function automatic logic model_term(input int t);
    int c;
    int v;
    c = sel_m[t];
    case (c) inside
      [1:5]: v = st[c-1];
      [9:17]: v = st[c-4];
      23: v = (vb_m >> t) & 1;
      24: v = (vb_m >> (4 + t)) & 1;
      25: v = (vb_m >> (8 + t)) & 1;
      34: v = (vb_m >> (12 + t)) & 1;
      26: v = st[14];
      [28:33]: v = st[c-12];
      36: v = st[22];
      [41:47]: v = cen_m ? card_bits[c-41] : 0;
      default: v = 0;
    endcase
    if (t == 1 && type_m == 0) begin
      return fast_pulse_in;
    end
    return 1'(v ^ ((pol_m >> t) & 1));
  endfunction

  // card enable goes in before the selects so card codes never route while disabled
  task automatic configure(input int ty, input int s0, input int s1, input int s2, input int s3,
                           input int pol, input int cen, input int vb);
    type_m = ty;
    sel_m = '{s0, s1, s2, s3};
    pol_m = pol;
    cen_m = cen;
    vb_m = vb;
    reg_write(`OFS_CARD_ENABLE, 16'(cen));
    reg_write(`OFS_TYPE_SEL, 16'(ty));
    reg_write(`OFS_OC_SEL, 16'(s0));
    reg_write(`OFS_FAST_SEL, 16'(s1));
    reg_write(`OFS_RELAY_A_SEL, 16'(s2));
    reg_write(`OFS_RELAY_B_SEL, 16'(s3));
    reg_write(`OFS_POLARITY, 16'(pol));
    reg_write(`OFS_VIRTUAL_BITS, 16'(vb));
  endtask

  // settle, then compare terminals, the loads' view and the read-only state word
  task automatic check_terms();
    logic [3:0] exp;
    repeat (3) @(posedge clk_sys);
    #1;
    exp = {model_term(3), model_term(2), model_term(1), model_term(0)};
    chk("terminals", {12'h000, exp}, {12'h000, relay_terminal_b_ff, relay_terminal_a_ff,
        fast_pulse_terminal_ff, oc_terminal_ff});
    chk("load view", {12'h000, exp}, {12'h000, seen_ff});
    reg_read(`OFS_TERM_STATE, rd);
    chk("state word", {12'h000, exp}, {12'h000, rd[3:0]});
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog sized well past the roughly 4800 cycles the sequence needs
  initial begin
    #2000000;
    err_total++;
    final_report();
  end

  initial begin
    logic [15:0] rst_tab [8];
    int width;
    rst_tab = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0005, 16'h0000, 16'h0000, 16'h0000};
    void'($urandom(32'h7b3f));
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      reg_read(4'(a), rd);
      if (a != 8) begin
        chk("register word", (a < 8) ? rst_tab[a] : 16'h0000, rd);
      end
    end
    // status change reaches the default relay selections one edge later
    @(posedge clk_sys);
    st[0] <= 1'b1;
    st[4] <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("relay pair", 16'h0003, {14'h0000, relay_terminal_b_ff, relay_terminal_a_ff});
    check_terms();
    // every code on all four terminals at once, random conditions and polarity
    for (int c = 0; c < 64; c++) begin
      @(posedge clk_sys);
      st <= 23'($urandom) & ~23'h008000;
      card_bits <= 7'($urandom);
      configure(1, c, c, c, c, $urandom % 16, $urandom % 2, $urandom % 65536);
      check_terms();
    end
    // independent random codes, type and pulse input
    for (int i = 0; i < 150; i++) begin
      @(posedge clk_sys);
      st <= 23'($urandom) & ~23'h008000;
      card_bits <= 7'($urandom);
      fast_pulse_in <= 1'($urandom);
      configure($urandom % 2, $urandom % 64, $urandom % 64, $urandom % 64, $urandom % 64,
                $urandom % 16, $urandom % 2, $urandom % 65536);
      check_terms();
    end
    // writes to the state word and to unmapped words change nothing
    reg_write(`OFS_TERM_STATE, 16'hFFFF);
    reg_write(4'hC, 16'hFFFF);
    check_terms();
    reg_read(4'hC, rd);
    chk("unmapped word", 16'h0000, rd);
    // index pulse stretched on two terminals, then released
    @(posedge clk_sys);
    st <= '0;
    configure(1, 27, 27, 0, 0, 0, 0, 0);
    @(posedge clk_sys);
    st[15] <= 1'b1;
    @(posedge clk_sys);
    st[15] <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("index stretch on", 16'h0003, {14'h0000, fast_pulse_terminal_ff, oc_terminal_ff});
    // the terminal already stood high after the two edges before the first look
    width = 2;
    repeat (PULSE_CYC + 4) begin
      @(posedge clk_sys);
      #1;
      width += int'(oc_terminal_ff);
    end
    chk("index width", 16'(PULSE_CYC), 16'(width));
    chk("index stretch off", 16'h0000, {14'h0000, fast_pulse_terminal_ff, oc_terminal_ff});
    final_report();
  end
endmodule
`default_nettype wire
